//--- design/lpe_pkg.sv
// Shared constants and types of the link power entry policy block.
package lpe_pkg;

   // ------------------------------------------------------------
   // Clock and widths
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int LAT_W = 24;
   typedef logic [LAT_W-1:0] lpe_lat_t;

   // ------------------------------------------------------------
   // Endpoint types and latency tolerance states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      EP_CTRL = 2'h0,
      EP_ISO  = 2'h1,
      EP_BULK = 2'h2,
      EP_INT  = 2'h3
   } lpe_ep_type_e;

   typedef enum logic {
      LT_IDLE   = 1'h0,
      LT_ACTIVE = 1'h1
   } lpe_lt_e;

   // ------------------------------------------------------------
   // Exit latency figures in nanoseconds
   // ------------------------------------------------------------
   localparam int HUB_DEPTH = 5;
   localparam int HUB_EXIT_NS = 1000;
   localparam int DEV_U1_EXIT_NS = 10000;
   localparam int DEV_U2_EXIT_NS = 2047000;
   localparam int U1_T2_NS = 3100;
   localparam int U1_T4_NS = 1300;
   localparam int U2_T2_NS = 3000;
   localparam int U2_T4_NS = 1000;
   localparam int SEL_GUARD_NS = 500;
   localparam int U2_PICK_GUARD_NS = 1000;
   localparam int WORST_U1PEL_NS = DEV_U1_EXIT_NS + HUB_DEPTH * HUB_EXIT_NS;
   localparam int WORST_U2PEL_NS = DEV_U2_EXIT_NS + HUB_DEPTH * HUB_EXIT_NS;
   localparam int WORST_U1SEL_NS = WORST_U1PEL_NS + U1_T2_NS + U1_T4_NS + SEL_GUARD_NS;
   localparam int WORST_U2SEL_NS = WORST_U2PEL_NS + U2_T2_NS + U2_T4_NS + SEL_GUARD_NS;

   // ------------------------------------------------------------
   // Latency tolerance and reported tolerance figures
   // ------------------------------------------------------------
   localparam int BELT_IDLE_MIN_NS = 1000000;
   localparam int BELT_ACTIVE_MIN_NS = 125000;
   localparam int TOL_IDLE_NS = 3100000;
   localparam int TOL_ACTIVE_NS = 145000;
   localparam int TOL_ACTIVE_U2_NS = BELT_ACTIVE_MIN_NS + WORST_U2SEL_NS;
   localparam int BELT_IDLE_RST_NS = TOL_IDLE_NS - WORST_U2SEL_NS;
   localparam int BELT_ACTIVE_RST_NS = TOL_ACTIVE_NS - WORST_U1SEL_NS;

   // ------------------------------------------------------------
   // Timer figures
   // ------------------------------------------------------------
   localparam int ERDY_TIMEOUT_NS = 1000000;
   localparam int BUS_INTERVAL_NS = 125000;

endpackage

//--- design/lpe_ep_if.sv
// Per-endpoint event and status carrier between the policy top and its trackers.
`timescale 1ns/1ns
interface lpe_ep_if;
   logic [1:0] ep_type;
   logic configured;
   logic ctrl_busy;
   logic nrdy;
   logic ack;
   logic ack_pp;
   logic erdy;
   logic host_req;
   logic eob;
   logic last_pkt;
   logic svc_start;
   logic idle;
   logic hold;

   modport top (output ep_type, configured, ctrl_busy, nrdy, ack, ack_pp, erdy, host_req,
      eob, last_pkt, svc_start, input idle, hold);
   modport ep (input ep_type, configured, ctrl_busy, nrdy, ack, ack_pp, erdy, host_req,
      eob, last_pkt, svc_start, output idle, hold);
endinterface

//--- design/lpe_ep_idle.sv
// Idle condition tracker for one endpoint.
`timescale 1ns/1ns
module lpe_ep_idle #(
   parameter int ERDY_TO_CYC = 125000
) (
   input wire logic clk,
   input wire logic rst,
   lpe_ep_if.ep epb
);
   localparam int TW = $clog2(ERDY_TO_CYC + 1);

   if (ERDY_TO_CYC < 1) begin : g_bad_to
      $error("ERDY_TO_CYC must be at least one");
   end

   logic erdy_pend_r;
   logic quiet_r;
   logic done_r;
   logic [TW-1:0] to_cnt_r;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic is_ctrl = (epb.ep_type == lpe_pkg::EP_CTRL);
   wire logic is_iso = (epb.ep_type == lpe_pkg::EP_ISO);
   wire logic is_bulk = (epb.ep_type == lpe_pkg::EP_BULK);
   wire logic is_int = (epb.ep_type == lpe_pkg::EP_INT);
   wire logic to_hit = erdy_pend_r && (to_cnt_r == TW'(ERDY_TO_CYC - 1));
   wire logic quiet_set = epb.nrdy || (epb.ack && !epb.ack_pp);
   wire logic quiet_clr = (epb.ack && epb.ack_pp) || epb.erdy;
   wire logic done_set = (is_int && epb.eob) || (is_iso && epb.last_pkt);
   wire logic erdy_pend_nxt = epb.erdy || (erdy_pend_r && !epb.host_req && !to_hit);
   wire logic quiet_nxt = quiet_set || (quiet_r && !quiet_clr);
   wire logic done_nxt = done_set || (done_r && !epb.svc_start);
   wire logic [TW-1:0] to_cnt_nxt = (epb.erdy || !erdy_pend_r) ? '0 : to_cnt_r + TW'(1);
   wire logic flow_idle = quiet_r && !erdy_pend_r;
   wire logic ctrl_idle = epb.configured && !epb.ctrl_busy && flow_idle;
   wire logic int_idle = !erdy_pend_r && (quiet_r || done_r);

   assign epb.idle = (is_ctrl && ctrl_idle) || (is_bulk && flow_idle) || (is_int && int_idle)
      || (is_iso && done_r);
   assign epb.hold = erdy_pend_r && (is_bulk || is_int);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         erdy_pend_r <= 1'b0;
         quiet_r <= 1'b0;
         done_r <= 1'b0;
         to_cnt_r <= '0;
      end else begin
         erdy_pend_r <= erdy_pend_nxt;
         quiet_r <= quiet_nxt;
         done_r <= done_nxt;
         to_cnt_r <= to_cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_ERDY_BLOCKS_IDLE: assert property (epb.erdy && !is_iso |=> !epb.idle)
      else $error("endpoint idle right after ERDY");
   AST_CTRL_NEEDS_CONFIG: assert property (is_ctrl && !epb.configured |-> !epb.idle)
      else $error("control endpoint idle while unconfigured");
   AST_ERDY_TIMEOUT: assert property (to_hit && !epb.erdy |=> !epb.hold)
      else $error("ERDY hold survived its timeout");
   AST_ISO_LAST_PKT: assert property (is_iso && epb.last_pkt && !epb.svc_start
      ##1 !epb.svc_start && is_iso |-> epb.idle)
      else $error("isochronous endpoint not idle after last packet");
   AST_INT_EOB_IDLE: assert property (is_int && epb.eob && !epb.erdy && !epb.svc_start
      && !erdy_pend_r |=> epb.idle || !is_int)
      else $error("interrupt endpoint not idle after end of burst");
endmodule

//--- design/lpe_belt_sub.sv
// Saturating subtraction of a system exit latency from a latency tolerance.
`timescale 1ns/1ns
module lpe_belt_sub (
   input wire lpe_pkg::lpe_lat_t tol_ns,
   input wire lpe_pkg::lpe_lat_t sel_ns,
   output lpe_pkg::lpe_lat_t belt_ns
);
   wire logic under = (sel_ns > tol_ns);

   assign belt_ns = under ? '0 : tol_ns - sel_ns;
endmodule

//--- design/lpe_top.sv
// Device link power entry policy with latency tolerance state and reported tolerance.
//
// Function
// - Request U1 or U2 only when every endpoint is idle.
// - Choose U2 when link unused longer than U2 exit latency plus guard, else U1.
// - Initiate U1 only with U1 enable set, U2 only with U2 enable set.
// - Control endpoint idle: configured, no transfer, quiet flow, no pending ERDY.
// - Bulk endpoint idle: NRDY sent or last ACK cleared pending, no ERDY.
// - After bulk ERDY keep U0 until host answers or ERDY timeout.
// - Interrupt endpoint idle: NRDY sent or last ACK cleared pending, no ERDY.
// - After interrupt ERDY keep U0 until host answers or ERDY timeout.
// - End of Burst marks interval done; link may sleep until next interval.
// - Isochronous endpoint idle after Last Packet until next service interval.
// - A known long wait such as spin-up sends the link to U2.
// - With timestamps needed, wake the link one exit latency before boundary.
// - Exit latency is worst case five hubs deep, or the received values.
// - Two tolerance states: idle by default, active when transfers are needed.
// - Target reported tolerance of 1 ms idle and 125 us active.
// - Idle tolerance value is total tolerance minus U2 system exit latency.
// - Worst U2 system latency from device exit, hub delays, t2, t4, guard.
// - Active tolerance value is total tolerance minus U1 system exit latency, or minus U2 with ALLOW_U2_ACTIVE.
// - Worst U1 system latency from device exit, hub delays, t2, t4, guard.
// - No U2 while active; if allowed, tolerate 125 us plus worst U2 latency.
// - Smaller actual system latencies give reported values above the minimums.
`timescale 1ns/1ns
module lpe_top #(
   parameter int N_EP = 4,
   parameter bit ALLOW_U2_ACTIVE = 1'b0,
   parameter int ERDY_TO_CYC = (lpe_pkg::ERDY_TIMEOUT_NS + lpe_pkg::CLK_PERIOD_NS - 1)
      / lpe_pkg::CLK_PERIOD_NS,
   parameter int BI_CYC = lpe_pkg::BUS_INTERVAL_NS / lpe_pkg::CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic configured,
   input wire logic ctrl_busy,
   input wire logic [N_EP-1:0][1:0] ep_type,
   input wire logic [N_EP-1:0] ep_nrdy,
   input wire logic [N_EP-1:0] ep_ack,
   input wire logic [N_EP-1:0] ep_ack_pp,
   input wire logic [N_EP-1:0] ep_erdy,
   input wire logic [N_EP-1:0] ep_host_req,
   input wire logic [N_EP-1:0] ep_eob,
   input wire logic [N_EP-1:0] ep_last_pkt,
   input wire logic [N_EP-1:0] ep_svc_start,
   input wire logic u1_enable,
   input wire logic u2_enable,
   input wire logic link_u0,
   input wire logic link_u2,
   input wire logic spinup_wait,
   input wire logic idle_known,
   input wire lpe_pkg::lpe_lat_t idle_ns,
   input wire logic xfer_need,
   input wire logic ts_need,
   input wire logic bus_boundary,
   input wire logic sel_strobe,
   input wire lpe_pkg::lpe_lat_t u1sel_ns,
   input wire lpe_pkg::lpe_lat_t u2sel_ns,
   input wire lpe_pkg::lpe_lat_t u1pel_ns,
   input wire lpe_pkg::lpe_lat_t u2pel_ns,
   output logic u1_req,
   output logic u2_req,
   output logic u0_wake,
   output logic lt_active,
   output logic all_idle,
   output lpe_pkg::lpe_lat_t belt_idle_ns,
   output lpe_pkg::lpe_lat_t belt_active_ns,
   output lpe_pkg::lpe_lat_t belt_ns,
   output logic belt_upd
);
   localparam int LW = lpe_pkg::LAT_W;
   localparam int CLK = lpe_pkg::CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (N_EP < 1) begin : g_bad_nep
      $error("N_EP must be at least one");
   end
   if (BI_CYC < 2 || BI_CYC >= (1 << LW)) begin : g_bad_bi
      $error("BI_CYC out of range");
   end
   if (ERDY_TO_CYC < 1) begin : g_bad_to
      $error("ERDY_TO_CYC must be at least one");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic u1_req_r;
   logic u2_req_r;
   logic u0_wake_r;
   logic all_idle_r;
   logic belt_upd_r;
   lpe_pkg::lpe_lt_e lt_r;
   lpe_pkg::lpe_lt_e lt_nxt;
   logic sel_known_r;
   lpe_pkg::lpe_lat_t u1sel_r;
   lpe_pkg::lpe_lat_t u2sel_r;
   lpe_pkg::lpe_lat_t u1pel_r;
   lpe_pkg::lpe_lat_t u2pel_r;
   lpe_pkg::lpe_lat_t belt_idle_r;
   lpe_pkg::lpe_lat_t belt_active_r;
   lpe_pkg::lpe_lat_t belt_r;
   lpe_pkg::lpe_lat_t bi_cnt_r;

   // ------------------------------------------------------------
   // Endpoint trackers
   // ------------------------------------------------------------
   logic [N_EP-1:0] ep_idle;
   logic [N_EP-1:0] ep_hold;
   lpe_ep_if ep_bus [N_EP] ();

   for (genvar i = 0; i < N_EP; i++) begin : g_ep
      assign ep_bus[i].ep_type = ep_type[i];
      assign ep_bus[i].configured = configured;
      assign ep_bus[i].ctrl_busy = ctrl_busy;
      assign ep_bus[i].nrdy = ep_nrdy[i];
      assign ep_bus[i].ack = ep_ack[i];
      assign ep_bus[i].ack_pp = ep_ack_pp[i];
      assign ep_bus[i].erdy = ep_erdy[i];
      assign ep_bus[i].host_req = ep_host_req[i];
      assign ep_bus[i].eob = ep_eob[i];
      assign ep_bus[i].last_pkt = ep_last_pkt[i];
      assign ep_bus[i].svc_start = ep_svc_start[i];
      assign ep_idle[i] = ep_bus[i].idle;
      assign ep_hold[i] = ep_bus[i].hold;
      lpe_ep_idle #(.ERDY_TO_CYC(ERDY_TO_CYC)) u_ep (
         .clk(clk),
         .rst(rst),
         .epb(ep_bus[i])
      );
   end

   wire logic all_idle_w = &ep_idle;
   wire logic hold_any = |ep_hold;

   // ------------------------------------------------------------
   // Exit latencies in use
   // ------------------------------------------------------------
   wire lpe_pkg::lpe_lat_t u1pel_eff = sel_known_r ? u1pel_r
      : LW'(lpe_pkg::WORST_U1PEL_NS);
   wire lpe_pkg::lpe_lat_t u2pel_eff = sel_known_r ? u2pel_r
      : LW'(lpe_pkg::WORST_U2PEL_NS);
   wire lpe_pkg::lpe_lat_t u1sel_eff = sel_known_r ? u1sel_r
      : LW'(lpe_pkg::WORST_U1SEL_NS);
   wire lpe_pkg::lpe_lat_t u2sel_eff = sel_known_r ? u2sel_r
      : LW'(lpe_pkg::WORST_U2SEL_NS);

   // ------------------------------------------------------------
   // Target selection
   // ------------------------------------------------------------
   wire logic [LW:0] u2_pick_ns = {1'b0, u2pel_eff} + (LW + 1)'(lpe_pkg::U2_PICK_GUARD_NS);
   wire logic long_idle = idle_known && ({1'b0, idle_ns} > u2_pick_ns);
   wire logic choose_u2 = spinup_wait || long_idle;
   wire logic u2_ok = choose_u2 && u2_enable;
   wire lpe_pkg::lpe_lat_t lead_ns = (link_u2 || choose_u2) ? u2pel_eff : u1pel_eff;
   wire lpe_pkg::lpe_lat_t lead_cyc = LW'((32'(lead_ns) + 32'(CLK - 1)) / 32'(CLK));
   wire logic ts_near = ts_need && (bi_cnt_r <= lead_cyc);
   wire logic may_enter = link_u0 && all_idle_w && !hold_any && !ts_near && !xfer_need;
   wire logic lt_allows_u2 = (lt_r == lpe_pkg::LT_IDLE) || ALLOW_U2_ACTIVE;
   wire logic u2_req_nxt = may_enter && u2_ok && lt_allows_u2;
   wire logic u1_req_nxt = may_enter && !u2_ok && u1_enable;
   wire logic u0_wake_nxt = ts_near && !link_u0;
   wire lpe_pkg::lpe_lat_t bi_cnt_nxt = (bus_boundary || bi_cnt_r == '0)
      ? LW'(BI_CYC - 1) : bi_cnt_r - LW'(1);

   // ------------------------------------------------------------
   // Latency tolerance state
   // ------------------------------------------------------------
   always_comb begin
      lt_nxt = lt_r;
      unique case (lt_r)
         lpe_pkg::LT_IDLE: begin
            if (xfer_need) begin
               lt_nxt = lpe_pkg::LT_ACTIVE;
            end
         end
         lpe_pkg::LT_ACTIVE: begin
            if (!xfer_need && may_enter && u2_ok && !ALLOW_U2_ACTIVE) begin
               lt_nxt = lpe_pkg::LT_IDLE;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Reported tolerance values
   // ------------------------------------------------------------
   lpe_pkg::lpe_lat_t belt_idle_w;
   lpe_pkg::lpe_lat_t belt_active_w;
   wire lpe_pkg::lpe_lat_t tol_active = ALLOW_U2_ACTIVE ? LW'(lpe_pkg::TOL_ACTIVE_U2_NS)
      : LW'(lpe_pkg::TOL_ACTIVE_NS);
   wire lpe_pkg::lpe_lat_t sel_active = ALLOW_U2_ACTIVE ? u2sel_eff : u1sel_eff;

   lpe_belt_sub u_belt_idle (
      .tol_ns(LW'(lpe_pkg::TOL_IDLE_NS)),
      .sel_ns(u2sel_eff),
      .belt_ns(belt_idle_w)
   );

   lpe_belt_sub u_belt_active (
      .tol_ns(tol_active),
      .sel_ns(sel_active),
      .belt_ns(belt_active_w)
   );

   wire lpe_pkg::lpe_lat_t belt_nxt = (lt_r == lpe_pkg::LT_ACTIVE) ? belt_active_r
      : belt_idle_r;

   // ------------------------------------------------------------
   // Sequential logic
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_known_r <= 1'b0;
         u1sel_r <= '0;
         u2sel_r <= '0;
         u1pel_r <= '0;
         u2pel_r <= '0;
      end else if (sel_strobe) begin
         sel_known_r <= 1'b1;
         u1sel_r <= u1sel_ns;
         u2sel_r <= u2sel_ns;
         u1pel_r <= u1pel_ns;
         u2pel_r <= u2pel_ns;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lt_r <= lpe_pkg::LT_IDLE;
         u1_req_r <= 1'b0;
         u2_req_r <= 1'b0;
         u0_wake_r <= 1'b0;
         all_idle_r <= 1'b0;
         bi_cnt_r <= LW'(BI_CYC - 1);
      end else begin
         lt_r <= lt_nxt;
         u1_req_r <= u1_req_nxt;
         u2_req_r <= u2_req_nxt;
         u0_wake_r <= u0_wake_nxt;
         all_idle_r <= all_idle_w;
         bi_cnt_r <= bi_cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         belt_idle_r <= LW'(lpe_pkg::BELT_IDLE_RST_NS);
         belt_active_r <= LW'(lpe_pkg::BELT_ACTIVE_RST_NS);
         belt_r <= LW'(lpe_pkg::BELT_IDLE_RST_NS);
         belt_upd_r <= 1'b0;
      end else begin
         belt_idle_r <= belt_idle_w;
         belt_active_r <= belt_active_w;
         belt_r <= belt_nxt;
         belt_upd_r <= (belt_nxt != belt_r);
      end
   end

   assign u1_req = u1_req_r;
   assign u2_req = u2_req_r;
   assign u0_wake = u0_wake_r;
   assign lt_active = (lt_r == lpe_pkg::LT_ACTIVE);
   assign all_idle = all_idle_r;
   assign belt_idle_ns = belt_idle_r;
   assign belt_active_ns = belt_active_r;
   assign belt_ns = belt_r;
   assign belt_upd = belt_upd_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_U1_NEEDS_ENABLE: assert property (u1_req_r |-> $past(u1_enable))
      else $error("U1 requested while not enabled");
   AST_U2_NEEDS_ENABLE: assert property (u2_req_r |-> $past(u2_enable))
      else $error("U2 requested while not enabled");
   AST_ENTRY_ALL_IDLE: assert property ((u1_req_r || u2_req_r) |-> $past(all_idle_w))
      else $error("entry requested with a busy endpoint");
   AST_HOLD_BLOCKS: assert property (hold_any |=> !u1_req_r && !u2_req_r)
      else $error("entry requested during ERDY hold");
   AST_NO_U2_ACTIVE: assert property (u2_req_r && !ALLOW_U2_ACTIVE
      |-> $past(lt_r) == lpe_pkg::LT_IDLE)
      else $error("U2 requested while in LT-active");
   AST_XFER_ACTIVE: assert property (xfer_need |=> lt_r == lpe_pkg::LT_ACTIVE)
      else $error("transfer need did not enter LT-active");
   AST_SPINUP_U2: assert property (spinup_wait && may_enter && u2_enable
      && lt_r == lpe_pkg::LT_IDLE |=> u2_req_r && !u1_req_r)
      else $error("spin-up wait did not pick U2");
   AST_TS_WAKE: assert property (u0_wake_r |-> $past(ts_need) && !$past(link_u0))
      else $error("wake raised without timestamp need");
   AST_BELT_IDLE: assert property (sel_strobe && u2sel_ns <= LW'(lpe_pkg::TOL_IDLE_NS)
      ##1 !sel_strobe |=> belt_idle_r == LW'(lpe_pkg::TOL_IDLE_NS) - $past(u2sel_ns, 2))
      else $error("idle tolerance value not recomputed");
endmodule

//--- tb/lpe_host_model.sv
// Upstream port model that answers each ERDY with a host request.
`timescale 1ns/1ns
module lpe_host_model #(
   parameter int DLY = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic answer,
   input wire logic [1:0] erdy,
   output logic [1:0] host_req
);
   // ------------------------------------------------------------
   // Answer timer
   // ------------------------------------------------------------
   int cnt [2];
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         host_req[i] <= 1'b0;
         if (rst || erdy[i]) begin
            cnt[i] <= (rst || !answer) ? 0 : DLY;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
            host_req[i] <= (cnt[i] == 1);
         end
      end
   end
endmodule

//--- tb/lpe_top_tb.sv
// Self-checking bench of the link power entry policy block.
`timescale 1ns/1ns
module lpe_top_tb;
   logic clk = 1'b0, rst = 1'b1, configured = 1'b0, ctrl_busy = 1'b0, answer = 1'b0;
   logic u1_enable = 1'b0, u2_enable = 1'b0, link_u0 = 1'b1, link_u2 = 1'b0;
   logic spinup_wait = 1'b0, idle_known = 1'b0, xfer_need = 1'b0, ts_need = 1'b0;
   logic bus_boundary = 1'b0, sel_strobe = 1'b0;
   logic [1:0][1:0] ep_type = {2'h2, 2'h2};
   logic [1:0] ep_nrdy = 2'h0, ep_ack = 2'h0, ep_ack_pp = 2'h0, ep_erdy = 2'h0;
   logic [1:0] ep_eob = 2'h0, ep_last_pkt = 2'h0, ep_svc_start = 2'h0, ep_host_req;
   lpe_pkg::lpe_lat_t idle_ns = 24'h000000, u1sel_ns = 24'h000000, u2sel_ns = 24'h000000;
   lpe_pkg::lpe_lat_t u1pel_ns = 24'h000000, u2pel_ns = 24'h000000;
   logic u1_req, u2_req, u0_wake, lt_active, all_idle, belt_upd;
   lpe_pkg::lpe_lat_t belt_idle_ns, belt_active_ns, belt_ns;
   int n_errors = 0, checked = 0;
   lpe_top #(.N_EP(2), .ERDY_TO_CYC(16), .BI_CYC(64)) lpe_top_i (.clk(clk), .rst(rst),
      .configured(configured), .ctrl_busy(ctrl_busy), .ep_type(ep_type), .ep_nrdy(ep_nrdy),
      .ep_ack(ep_ack), .ep_ack_pp(ep_ack_pp), .ep_erdy(ep_erdy), .ep_host_req(ep_host_req),
      .ep_eob(ep_eob), .ep_last_pkt(ep_last_pkt), .ep_svc_start(ep_svc_start),
      .u1_enable(u1_enable), .u2_enable(u2_enable), .link_u0(link_u0), .link_u2(link_u2),
      .spinup_wait(spinup_wait), .idle_known(idle_known), .idle_ns(idle_ns),
      .xfer_need(xfer_need), .ts_need(ts_need), .bus_boundary(bus_boundary),
      .sel_strobe(sel_strobe), .u1sel_ns(u1sel_ns), .u2sel_ns(u2sel_ns), .u1pel_ns(u1pel_ns),
      .u2pel_ns(u2pel_ns), .u1_req(u1_req), .u2_req(u2_req), .u0_wake(u0_wake),
      .lt_active(lt_active), .all_idle(all_idle), .belt_idle_ns(belt_idle_ns),
      .belt_active_ns(belt_active_ns), .belt_ns(belt_ns), .belt_upd(belt_upd));
   lpe_host_model #(.DLY(3)) lpe_host_model_i (.clk(clk), .rst(rst), .answer(answer),
      .erdy(ep_erdy), .host_req(ep_host_req));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   task results();
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task t(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Ends every pulse after one cycle and lets the answer settle.
   task clr();
      t(1);
      {ep_nrdy, ep_ack, ep_ack_pp, ep_erdy, ep_eob, ep_last_pkt, ep_svc_start} = '0;
      {xfer_need, bus_boundary, sel_strobe} = 3'h0;
      t(4);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset();
      chk(belt_idle_ns, 24'h0FEC2C, "idle value after reset");
      chk(belt_active_ns, 24'h01E8AC, "active value after reset");
      chk(belt_ns, 24'h0FEC2C, "reported value after reset");
      chk(lt_active, 1'b0, "default tolerance state");
      chk({u2_req, u1_req, u0_wake, all_idle, belt_upd}, 5'h00, "outputs after reset");
      $display("t_reset done");
   endtask
   task t_entry();
      u1_enable = 1'b1;
      ep_nrdy = 2'h1;
      clr();
      chk({all_idle, u1_req}, 2'h0, "entry with one busy endpoint");
      ep_nrdy = 2'h2;
      clr();
      chk({all_idle, u1_req}, 2'h3, "entry with all bulk idle");
      u1_enable = 1'b0;
      t(3);
      chk(u1_req, 1'b0, "entry while disabled");
      u1_enable = 1'b1;
      ep_erdy = 2'h1;
      clr();
      ep_nrdy = 2'h1;
      clr();
      chk(u1_req, 1'b0, "entry while ERDY pending");
      t(12);
      chk(u1_req, 1'b1, "entry after ERDY timeout");
      answer = 1'b1;
      ep_erdy = 2'h2;
      clr();
      ep_nrdy = 2'h2;
      clr();
      chk(u1_req, 1'b1, "entry after host answer");
      $display("t_entry done");
   endtask
   task t_types();
      ep_type = {2'h3, 2'h0};
      configured = 1'b1;
      ep_nrdy = 2'h1;
      ep_ack = 2'h2;
      ep_ack_pp = 2'h2;
      clr();
      chk(u1_req, 1'b0, "interrupt packets pending");
      ep_eob = 2'h2;
      clr();
      chk(u1_req, 1'b1, "interrupt burst done");
      ctrl_busy = 1'b1;
      t(4);
      chk(u1_req, 1'b0, "control transfer running");
      ctrl_busy = 1'b0;
      configured = 1'b0;
      t(4);
      chk(u1_req, 1'b0, "control endpoint unconfigured");
      configured = 1'b1;
      ep_svc_start = 2'h2;
      clr();
      chk(u1_req, 1'b0, "interrupt new interval");
      ep_type = {2'h1, 2'h2};
      ep_eob = 2'h2;
      clr();
      chk(u1_req, 1'b0, "burst flag on isochronous");
      ep_last_pkt = 2'h2;
      clr();
      chk(u1_req, 1'b1, "isochronous interval done");
      $display("t_types done");
   endtask
   task t_u2();
      u2_enable = 1'b1;
      idle_known = 1'b1;
      idle_ns = 24'h1F5389;
      t(4);
      chk({u2_req, u1_req}, 2'h2, "long known idle");
      idle_ns = 24'h1F5388;
      t(4);
      chk({u2_req, u1_req}, 2'h1, "idle at the limit");
      xfer_need = 1'b1;
      clr();
      chk(lt_active, 1'b1, "transfer need");
      chk(belt_ns, 24'h01E8AC, "active reported value");
      spinup_wait = 1'b1;
      t(1);
      chk(u2_req, 1'b0, "no U2 while active");
      t(1);
      chk(belt_upd, 1'b1, "update pulse with the state change");
      t(3);
      chk({lt_active, u2_req, belt_upd}, 3'h2, "spin-up wait");
      chk(belt_ns, 24'h0FEC2C, "idle reported value");
      spinup_wait = 1'b0;
      u2_enable = 1'b0;
      idle_known = 1'b0;
      $display("t_u2 done");
   endtask
   task t_sel();
      u1sel_ns = 24'h002710;
      u2sel_ns = 24'h0F4240;
      u1pel_ns = 24'h000050;
      u2pel_ns = 24'h000100;
      sel_strobe = 1'b1;
      clr();
      chk(belt_idle_ns, 24'h200B20, "idle value from stored latency");
      chk(belt_active_ns, 24'h020F58, "active value from stored latency");
      chk(belt_ns, 24'h200B20, "reported value follows");
      ts_need = 1'b1;
      link_u0 = 1'b0;
      bus_boundary = 1'b1;
      t(1);
      bus_boundary = 1'b0;
      t(53);
      chk(u0_wake, 1'b0, "wake too early");
      t(1);
      chk(u0_wake, 1'b1, "wake before boundary");
      link_u2 = 1'b1;
      bus_boundary = 1'b1;
      t(1);
      bus_boundary = 1'b0;
      t(31);
      chk(u0_wake, 1'b0, "U2 wake too early");
      t(1);
      chk(u0_wake, 1'b1, "U2 wake before boundary");
      ts_need = 1'b0;
      $display("t_sel done");
   endtask
   task t_rerun();
      rst = 1'b1;
      t(2);
      rst = 1'b0;
      t(1);
      t_reset();
      $display("t_rerun done");
   endtask
   initial begin
      t(5);
      rst = 1'b0;
      t(1);
      t_reset();
      t_entry();
      t_types();
      t_u2();
      t_sel();
      t_rerun();
      results();
   end
endmodule
